// ### src/fcm_meter.sv
`timescale 1ns/1ps
`include "fcm_cfg.svh"
module fcm_meter
  import fcm_pkg::*;
#(
  parameter int NCH = 8,
  // Clocks per timing tick; shortened only to keep simulations brief
  parameter int TICK_CYC = `FCM_TICK_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Edge-selected, debounced pulse inputs
  input wire logic [NCH-1:0] pulse_in,
  // Range configuration
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_ch,
  input wire logic [19:0] cfg_fmin,
  input wire logic [19:0] cfg_fmax,
  output logic cfg_err_ff,
  // Converter selection and calibration
  input wire logic [1:0] sel_lo,
  input wire logic [1:0] sel_hi,
  input wire logic [15:0] cal_gain_lo,
  input wire logic signed [15:0] cal_off_lo,
  input wire logic [15:0] cal_gain_hi,
  input wire logic signed [15:0] cal_off_hi,
  // Converter codes and status
  output logic [11:0] dac_lo_ff,
  output logic [11:0] dac_hi_ff,
  output logic [NCH-1:0] valid_ff
);

  // Gain is unsigned with 1.0 at GAIN_ONE; result clamps to the code range
  function automatic logic [11:0] fcm_cal(input logic [11:0] c, input logic [15:0] g,
                                         input logic signed [15:0] o);
    logic [31:0] p;
    logic signed [31:0] v;
    p = 32'(c) * 32'(g);
    v = $signed(p >> `FCM_GAIN_SHIFT) + 32'(o);
    if (v < 0) return 12'h000;
    else if (v > 32'sh00000FFF) return `FCM_CODE_MAX;
    else return v[11:0];
  endfunction

  logic [5:0] tick_cnt_ff;
  logic tick;
  logic [19:0] fmin_ff [NCH];
  logic [19:0] fmax_ff [NCH];
  logic [NCH-1:0] prev_ff;
  logic [NCH-1:0] run_ff;
  logic [NCH-1:0] pend_ff;
  logic [NCH-1:0] edge_in;
  logic [NCH-1:0] gate_ok;
  logic [NCH-1:0] pend_clr;
  logic [31:0] tcnt_ff [NCH];
  logic [31:0] ncnt_ff [NCH];
  logic [39:0] acc_ff [NCH];
  logic [31:0] lat_t_ff [NCH];
  logic [31:0] lat_n_ff [NCH];
  logic [11:0] code_ff [NCH];
  logic cfg_ok;
  fcm_dv_state_t dv_state_ff;
  logic [2:0] dv_ch_ff;
  logic [2:0] grant_ch;
  logic [63:0] dv_rem_ff;
  logic [63:0] dv_den_ff;
  logic dv_low_ff;
  logic dv_over_ff;
  logic [3:0] dv_bit_ff;
  logic [11:0] dv_q_ff;
  logic [63:0] ld_num;
  logic [63:0] ld_sub;
  logic [63:0] ld_den;
  logic [64:0] rem_sh;

  // Half-microsecond timing tick
  assign tick = (tick_cnt_ff == 6'(TICK_CYC - 1));
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) tick_cnt_ff <= 6'h00;
    else if (tick) tick_cnt_ff <= 6'h00;
    else tick_cnt_ff <= tick_cnt_ff + 6'h01;
  end

  // Limits outside 0..1 MHz or inverted are refused and flagged
  assign cfg_ok = (cfg_fmax <= `FCM_FLIM_HZ) && (cfg_fmin < cfg_fmax);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cfg_err_ff <= 1'b0;
    else cfg_err_ff <= cfg_wr && !cfg_ok;
  end

  // Lowest pending channel gets the divider
  always_comb begin
    grant_ch = 3'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (pend_ff[k]) grant_ch = 3'(k);
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      assign edge_in[i] = pulse_in[i] && !prev_ff[i];
      // Span accumulated per tick reaches 4096*fmax when the gate is long enough
      assign gate_ok[i] = (acc_ff[i] >= {8'h00, fmax_ff[i], 12'h000}) && (tcnt_ff[i] != 32'h0);
      assign pend_clr[i] = (dv_state_ff == dv_idle) && (grant_ch == 3'(i)) && pend_ff[i];

      // Independent range per channel
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          fmin_ff[i] <= `FCM_FMIN_RST;
          fmax_ff[i] <= `FCM_FMAX_RST;
        end else if (cfg_wr && cfg_ok && cfg_ch == 3'(i)) begin
          fmin_ff[i] <= cfg_fmin;
          fmax_ff[i] <= cfg_fmax;
        end
      end

      // Gate engine; a new range restarts the channel, yet a result already pending is divided with the new range
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          prev_ff[i] <= 1'b0;
          run_ff[i] <= 1'b0;
          tcnt_ff[i] <= 32'h0;
          ncnt_ff[i] <= 32'h0;
          acc_ff[i] <= 40'h0;
          lat_t_ff[i] <= 32'h0;
          lat_n_ff[i] <= 32'h0;
        end else begin
          prev_ff[i] <= pulse_in[i];
          if (cfg_wr && cfg_ok && cfg_ch == 3'(i)) begin
            run_ff[i] <= 1'b0;
          end else if (!run_ff[i]) begin
            if (edge_in[i]) begin
              run_ff[i] <= 1'b1;
              tcnt_ff[i] <= 32'h0;
              ncnt_ff[i] <= 32'h0;
              acc_ff[i] <= 40'h0;
            end
          end else if (edge_in[i] && gate_ok[i]) begin
            lat_t_ff[i] <= tcnt_ff[i];
            lat_n_ff[i] <= ncnt_ff[i] + 32'h1;
            tcnt_ff[i] <= 32'h0;
            ncnt_ff[i] <= 32'h0;
            acc_ff[i] <= 40'h0;
          end else begin
            if (edge_in[i]) ncnt_ff[i] <= ncnt_ff[i] + 32'h1;
            if (tick) tcnt_ff[i] <= tcnt_ff[i] + 32'h1;
            if (tick && !gate_ok[i]) acc_ff[i] <= acc_ff[i] + 40'(fmax_ff[i] - fmin_ff[i]);
          end
        end
      end

      // Completion flag; a new completion wins over the divider's clear
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) pend_ff[i] <= 1'b0;
        // Refused writes leave the channel running, so only accepted ones drop the result
        else if (run_ff[i] && edge_in[i] && gate_ok[i] && !(cfg_wr && cfg_ok && cfg_ch == 3'(i))) pend_ff[i] <= 1'b1;
        else if (pend_clr[i]) pend_ff[i] <= 1'b0;
      end

      // Stored code changes only at the end of a division
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          code_ff[i] <= 12'h000;
          valid_ff[i] <= 1'b0;
        end else if (dv_state_ff == dv_done && dv_ch_ff == 3'(i)) begin
          code_ff[i] <= dv_q_ff;
          valid_ff[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Operands: N*2e6 against fmin*T, scaled by span*T
  always_comb begin
    ld_num = 64'(lat_n_ff[dv_ch_ff]) * `FCM_TICKS_PER_S;
    ld_sub = 64'(fmin_ff[dv_ch_ff]) * 64'(lat_t_ff[dv_ch_ff]);
    ld_den = 64'(fmax_ff[dv_ch_ff] - fmin_ff[dv_ch_ff]) * 64'(lat_t_ff[dv_ch_ff]);
    rem_sh = {dv_rem_ff, 1'b0};
  end

  // Shared divider; a few dozen cycles at most, far inside the 4 ms budget
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dv_state_ff <= dv_idle;
      dv_ch_ff <= 3'h0;
      dv_rem_ff <= 64'h0;
      dv_den_ff <= 64'h0;
      dv_low_ff <= 1'b0;
      dv_over_ff <= 1'b0;
      dv_bit_ff <= 4'h0;
      dv_q_ff <= 12'h000;
    end else begin
      unique case (dv_state_ff)
        dv_idle: if (|pend_ff) begin
          dv_ch_ff <= grant_ch;
          dv_state_ff <= dv_load;
        end
        dv_load: begin
          dv_low_ff <= (ld_num <= ld_sub);
          dv_over_ff <= (ld_num > ld_sub) && ((ld_num - ld_sub) >= ld_den);
          dv_rem_ff <= ld_num - ld_sub;
          dv_den_ff <= ld_den;
          dv_bit_ff <= `FCM_DIV_STEPS;
          dv_q_ff <= 12'h000;
          dv_state_ff <= dv_run;
        end
        dv_run: begin
          if (dv_low_ff) begin
            dv_q_ff <= 12'h000;
            dv_state_ff <= dv_done;
          end else if (dv_over_ff) begin
            dv_q_ff <= `FCM_CODE_MAX;
            dv_state_ff <= dv_done;
          end else begin
            // Restoring division yields 12 quotient bits
            if (rem_sh >= {1'b0, dv_den_ff}) begin
              dv_rem_ff <= 64'(rem_sh - {1'b0, dv_den_ff});
              dv_q_ff <= {dv_q_ff[10:0], 1'b1};
            end else begin
              dv_rem_ff <= rem_sh[63:0];
              dv_q_ff <= {dv_q_ff[10:0], 1'b0};
            end
            dv_bit_ff <= dv_bit_ff - 4'h1;
            if (dv_bit_ff == 4'h1) dv_state_ff <= dv_done;
          end
        end
        dv_done: dv_state_ff <= dv_idle;
      endcase
    end
  end

  // Converter outputs follow selection and the corrected stored code
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dac_lo_ff <= 12'h000;
      dac_hi_ff <= 12'h000;
    end else begin
      dac_lo_ff <= fcm_cal(code_ff[{1'b0, sel_lo}], cal_gain_lo, cal_off_lo);
      dac_hi_ff <= fcm_cal(code_ff[{1'b1, sel_hi}], cal_gain_hi, cal_off_hi);
    end
  end

  // Checks
  a_cfg_refuse: assert property (@(posedge mclk) disable iff (!nrst)
    (cfg_wr && cfg_fmax > `FCM_FLIM_HZ) |=> cfg_err_ff && $stable(fmax_ff[0]))
    else $error("limit above 1 MHz accepted");
  a_range_store: assert property (@(posedge mclk) disable iff (!nrst)
    (cfg_wr && cfg_ok && cfg_ch == 3'h5) |=> fmax_ff[5] == $past(cfg_fmax) && fmin_ff[5] == $past(cfg_fmin))
    else $error("channel limits not stored");
  a_gate_length: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pend_ff[0]) |-> 64'(lat_t_ff[0]) * 64'(fmax_ff[0] - fmin_ff[0]) >= 64'({fmax_ff[0], 12'h000}))
    else $error("gate shorter than minimum");
  a_edge_close: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pend_ff[0]) |-> $past(edge_in[0]))
    else $error("measurement closed without input edge");
  a_div_bound: assert property (@(posedge mclk) disable iff (!nrst)
    (dv_state_ff == dv_load) |-> ##[2:13] (dv_state_ff == dv_done))
    else $error("division too slow");
  a_clamp_low: assert property (@(posedge mclk) disable iff (!nrst)
    (dv_state_ff == dv_run && dv_low_ff) |=> ##1 code_ff[dv_ch_ff] == 12'h000)
    else $error("low frequency not zero");
  a_clamp_high: assert property (@(posedge mclk) disable iff (!nrst)
    (dv_state_ff == dv_run && !dv_low_ff && dv_over_ff) |=> ##1 code_ff[dv_ch_ff] == `FCM_CODE_MAX)
    else $error("high frequency not 4095");
  a_code_stable: assert property (@(posedge mclk) disable iff (!nrst)
    (dv_state_ff != dv_done) |=> $stable(code_ff[0]) && $stable(code_ff[7]))
    else $error("code changed without completion");
  a_sel_follow: assert property (@(posedge mclk) disable iff (!nrst)
    (cal_gain_hi == `FCM_GAIN_ONE && cal_off_hi == 16'sh0000) |=> dac_hi_ff == $past(code_ff[{1'b1, sel_hi}]))
    else $error("converter not showing selected code");
  a_hold_last: assert property (@(posedge mclk) disable iff (!nrst)
    (dv_state_ff == dv_idle && $past(dv_state_ff) == dv_idle && $stable(sel_lo) && $stable(cal_gain_lo)
     && $stable(cal_off_lo)) |=> $stable(dac_lo_ff))
    else $error("output moved without new result");
  c_complete: cover property (@(posedge mclk) disable iff (!nrst) $rose(pend_ff[0]));
  c_full_scale: cover property (@(posedge mclk) disable iff (!nrst)
    dv_state_ff == dv_done && dv_q_ff == `FCM_CODE_MAX);
  c_mid_code: cover property (@(posedge mclk) disable iff (!nrst)
    dv_state_ff == dv_done && dv_q_ff != 12'h000 && dv_q_ff != `FCM_CODE_MAX);
  c_sel_change: cover property (@(posedge mclk) disable iff (!nrst) !$stable(sel_hi) && valid_ff[4]);

endmodule

// ### src/fcm_cfg.svh
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH

// Clock and timing base
`define FCM_CLK_NS 10
`define FCM_TICK_NS 500
`define FCM_TICK_CYC (`FCM_TICK_NS / `FCM_CLK_NS)
`define FCM_TICKS_PER_S 64'h1E8480
`define FCM_PROC_MS 4

// Frequency limits in Hz
`define FCM_FLIM_HZ 20'hF4240
`define FCM_FMIN_RST 20'h00000
`define FCM_FMAX_RST 20'hF4240

// Code scaling and calibration
`define FCM_CODE_SHIFT 12
`define FCM_CODE_MAX 12'hFFF
`define FCM_DIV_STEPS 4'hC
`define FCM_GAIN_ONE 16'h4000
`define FCM_GAIN_SHIFT 14

`endif

// ### src/fcm_pkg.sv
package fcm_pkg;
  // Shared divider sequence
  typedef enum logic [1:0] {dv_idle, dv_load, dv_run, dv_done} fcm_dv_state_t;
endpackage

// ### tb/fcm_pulse_src.sv
`timescale 1ns/1ps
module fcm_pulse_src #(
  parameter int PER [8] = '{default: 100}
) (
  // Clock
  input wire logic mclk,
  // Per-channel run enables
  input wire logic [7:0] en,
  // Square-wave pulse outputs
  output logic [7:0] pulse
);
  int cnt [8];
  initial pulse = 8'h00;
  // Launched on the falling edge so the meter always samples settled levels
  always @(negedge mclk) begin
    for (int c = 0; c < 8; c++) begin
      if (!en[c]) begin
        cnt[c] <= 0;
        pulse[c] <= 1'b0;
      end else begin
        cnt[c] <= (cnt[c] + 1 == PER[c]) ? 0 : cnt[c] + 1;
        pulse[c] <= (cnt[c] < PER[c] / 2);
      end
    end
  end
endmodule

// ### tb/fcm_meter_test.sv
`timescale 1ns/1ps
module fcm_meter_test;
  // Stimulus table: pulse period in mclk cycles and range in Hz per channel
  // A ten-cycle tick keeps gates short; readings then scale by TICK/50
  localparam int TICK = 10;
  localparam int PER [8] = '{40, 40, 400, 80, 40, 80, 16, 200};
  localparam longint FMIN [8] = '{0, 0, 100000, 0, 100000, 0, 0, 0};
  localparam longint FMAX [8] = '{1000000, 100000, 1000000, 1000000, 1000000, 500000, 1000000, 1000000};
  logic mclk, nrst, cfg_wr, cfg_err_ff;
  logic [2:0] cfg_ch;
  logic [19:0] cfg_fmin, cfg_fmax;
  logic [1:0] sel_lo, sel_hi;
  logic [15:0] cal_gain_lo, cal_gain_hi;
  logic signed [15:0] cal_off_lo, cal_off_hi;
  logic [11:0] dac_lo_ff, dac_hi_ff;
  logic [7:0] valid_ff, pulse_in, pulse_en;
  int fails, cmp_count;

  fcm_meter #(.TICK_CYC(TICK)) fcm_meter_i (.mclk(mclk), .nrst(nrst), .pulse_in(pulse_in), .cfg_wr(cfg_wr),
    .cfg_ch(cfg_ch),
    .cfg_fmin(cfg_fmin), .cfg_fmax(cfg_fmax), .cfg_err_ff(cfg_err_ff), .sel_lo(sel_lo), .sel_hi(sel_hi),
    .cal_gain_lo(cal_gain_lo), .cal_off_lo(cal_off_lo), .cal_gain_hi(cal_gain_hi), .cal_off_hi(cal_off_hi),
    .dac_lo_ff(dac_lo_ff), .dac_hi_ff(dac_hi_ff), .valid_ff(valid_ff));
  fcm_pulse_src #(.PER(PER)) fcm_pulse_src_i (.mclk(mclk), .en(pulse_en), .pulse(pulse_in));

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic finish_test;
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Window compare shared by every check of a known value
  task automatic chk_in(input longint v, input longint lo, input longint hi, input string what);
    cmp_count++;
    if (v < lo || v > hi) begin
      fails++;
      $display("Error %0t: %s is %0d, expected %0d..%0d", $time, what, v, lo, hi);
    end
  endtask

  // Four-state value against expectation; an unknown bit always fails
  task automatic chk(input logic [11:0] got, input longint exp, input longint tol, input string what);
    if (^got === 1'bx) begin
      cmp_count++;
      fails++;
      $display("Error %0t: %s is unknown", $time, what);
    end else
      chk_in(got, exp - tol, exp + tol, what);
  endtask

  // Ideal clamped code for the source frequency on channel c as read with the TICK-cycle tick (scaled by TICK/50)
  function automatic longint exp_code(input int c);
    longint f, d;
    f = 2000000 * TICK / PER[c];
    d = (f <= FMIN[c]) ? 0 : 4096 * (f - FMIN[c]) / (FMAX[c] - FMIN[c]);
    return (d > 4095) ? 4095 : d;
  endfunction

  task automatic cfg(input int c, input longint fmin, input longint fmax, input logic bad);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_ch = c[2:0];
    cfg_fmin = fmin[19:0];
    cfg_fmax = fmax[19:0];
    @(negedge mclk);
    cfg_wr = 1'b0;
    chk({11'h000, cfg_err_ff}, bad, 0, "cfg_err_ff after write");
    @(negedge mclk);
    chk({11'h000, cfg_err_ff}, 0, 0, "cfg_err_ff one cycle later");
  endtask

  // Select a channel on its converter and take the settled code
  task automatic read_ch(input int c, output logic [11:0] got);
    @(negedge mclk);
    if (c < 4)
      sel_lo = c[1:0];
    else
      sel_hi = 2'(c - 4);
    repeat (3) @(negedge mclk);
    got = (c < 4) ? dac_lo_ff : dac_hi_ff;
  endtask

  // Own range per channel, then two refused writes that must leave ranges alone
  task automatic t_config;
    for (int c = 0; c < 8; c++) cfg(c, FMIN[c], FMAX[c], 1'b0);
    cfg(1, 0, 1000001, 1'b1);
    cfg(5, 300000, 300000, 1'b1);
  endtask

  // All channels in parallel: completion time against gate length, then codes
  task automatic t_measure;
    logic [7:0] seen;
    logic [11:0] got;
    longint g;
    int n;
    seen = 8'h00;
    @(negedge mclk);
    pulse_en = 8'hFF;
    for (n = 1; n <= 60000 && seen !== 8'hFF; n++) begin
      @(negedge mclk);
      for (int c = 0; c < 8; c++) begin
        if (valid_ff[c] === 1'b1 && !seen[c]) begin
          seen[c] = 1'b1;
          g = (4096 * FMAX[c] + FMAX[c] - FMIN[c] - 1) / (FMAX[c] - FMIN[c]);
          chk_in(n, (g - 1) * TICK, g * TICK + 2 * PER[c] + 200, "result time");
        end
      end
    end
    if (seen !== 8'hFF) begin
      fails++;
      $display("Error %0t: results never completed", $time);
    end
    pulse_en = 8'h00;
    // Pending results still drain through the shared divider
    repeat (200) @(negedge mclk);
    for (int c = 0; c < 8; c++) begin
      read_ch(c, got);
      g = exp_code(c);
      chk(got, g, (g == 0 || g == 4095) ? 0 : 3, "channel code");
    end
  endtask

  // Gain halved on lo and doubled on hi, offset shifts, with clamping at both ends
  task automatic t_calib;
    logic [11:0] got;
    @(negedge mclk);
    cal_gain_lo = 16'h2000;
    cal_off_lo = 16'sh0010;
    cal_gain_hi = 16'h8000;
    read_ch(1, got);
    chk(got, 2063, 0, "lo half gain plus offset");
    read_ch(6, got);
    chk(got, 4095, 0, "hi double gain clamp");
    cal_gain_lo = 16'h4000;
    cal_off_lo = -16'sh0010;
    read_ch(0, got);
    chk(got, exp_code(0) - 16, 3, "lo negative offset");
    read_ch(2, got);
    chk(got, 0, 0, "lo clamp at zero");
    cal_off_lo = 16'sh0000;
    cal_gain_hi = 16'h4000;
  endtask

  // No new completions: repeated reads keep the last result
  task automatic t_hold;
    logic [11:0] a, b;
    read_ch(3, a);
    read_ch(7, b);
    repeat (1000) @(negedge mclk);
    read_ch(3, b);
    chk(b, a, 0, "repeat read");
    chk({4'h0, valid_ff}, 255, 0, "valid held");
  endtask

  initial begin
    fails = 0;
    cmp_count = 0;
    nrst = 1'b0;
    cfg_wr = 1'b0;
    cfg_ch = 3'h0;
    cfg_fmin = 20'h00000;
    cfg_fmax = 20'h00000;
    sel_lo = 2'h0;
    sel_hi = 2'h0;
    cal_gain_lo = 16'h4000;
    cal_gain_hi = 16'h4000;
    cal_off_lo = 16'sh0000;
    cal_off_hi = 16'sh0000;
    pulse_en = 8'h00;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    chk({4'h0, valid_ff}, 0, 0, "valid after reset");
    chk(dac_lo_ff, 0, 0, "dac after reset");
    t_config();
    t_measure();
    t_calib();
    t_hold();
    finish_test();
  end
endmodule
